// File: sim/fetch_model.sv
`timescale 1ns/1ps
module fetch_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // pacing: idle cycles after each byte
  input wire logic [1:0] gap,
  // byte stream into the decoder
  output logic in_valid,
  output logic [7:0] in_byte
);
  logic [7:0] q[$];
  logic [1:0] wait_n;

  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask

  initial begin
    in_valid = 1'b0;
    in_byte = 8'h00;
    wait_n = 2'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    if (rst || q.size() == 0 || wait_n != 2'h0) begin
      in_valid <= 1'b0;
      // idle byte keeps toggling so a stale value is never mistaken for data
      in_byte <= ~in_byte;
      if (wait_n != 2'h0) begin
        wait_n <= wait_n - 2'h1;
      end
    end else begin
      in_valid <= 1'b1;
      in_byte <= q.pop_front();
      wait_n <= gap;
    end
  end
endmodule

// File: sim/test_muldiv_shift_logic_decode.sv
`timescale 1ns/1ps
module test_muldiv_shift_logic_decode;
  import muldiv_pkg::*;
  typedef struct packed {
    logic [28:0] key;
    logic [15:0] imm;
    logic [10:0] sh;
    logic [7:0] dir;
    logic [2:0] chk;
  } exp_t;
  logic clock;
  logic rst;
  logic bus_8bit;
  logic [7:0] count_register_low;
  logic [1:0] gap;
  logic in_valid;
  logic [7:0] in_byte;
  logic out_valid;
  decode_t out_decode;
  timing_t out_timing;
  int n_mismatch;
  int n_checks;
  exp_t expq[$];
  exp_t nx;
  exp_t e;
  logic [28:0] g;

  muldiv_shift_logic_decode dut (.clock(clock), .rst(rst), .in_valid(in_valid), .in_byte(in_byte),
    .bus_8bit(bus_8bit), .count_register_low(count_register_low), .out_valid(out_valid),
    .out_decode(out_decode), .out_timing(out_timing));
  fetch_model u_fetch (.clock(clock), .rst(rst), .gap(gap), .in_valid(in_valid), .in_byte(in_byte));

  initial clock = 1'b0;
  always #12.5 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [28:0] got, input logic [28:0] want);
    n_checks++;
    if (got !== want) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h want=%h", $time, got, want);
    end
  endtask

  // every decode pulse is matched against the oldest expectation
  always @(posedge clock) begin
    if (rst === 1'b0 && out_valid === 1'b1) begin
      if (expq.size() == 0) begin
        cmp(29'h1, 29'h0);
      end else begin
        e = expq.pop_front();
        g = {out_decode.recognised, out_decode.op, out_decode.width_word, out_decode.length, out_timing};
        // width is meaningless for bytes outside the group
        if (e.key[27:23] == OP_NONE) g[22] = e.key[22];
        cmp(g, e.key);
        if (e.chk[0]) cmp(out_decode.imm, e.imm);
        if (e.chk[1]) cmp({out_decode.shift_op, out_decode.shift_count}, e.sh);
        if (e.chk[2]) cmp({out_decode.dir_to_reg, out_decode.mem_operand, out_decode.reg_sel, out_decode.rm_sel}, e.dir);
      end
    end
  end

  // bytes are left-justified in b, n of them sent
  task automatic ins(input logic [31:0] b, input int n, input op_t op, input logic w,
                     input logic [8:0] mn, input logic [8:0] mx);
    @(negedge clock);
    nx.key = {op != OP_NONE, op, w, n[3:0], mn, mx};
    // memory flag and register fields come straight from the modrm byte sent
    nx.dir[6:0] = {b[23:22] != 2'b11, b[21:16]};
    expq.push_back(nx);
    for (int i = 0; i < n; i++) u_fetch.push(b[31 - 8 * i -: 8]);
    nx.chk = 3'h0;
  endtask

  task automatic imx(input logic [15:0] v);
    nx.imm = v;
    nx.chk[0] = 1'b1;
  endtask

  task automatic dirx(input logic d);
    nx.dir[7] = d;
    nx.chk[2] = 1'b1;
  endtask

  task automatic shf(input logic [31:0] b, input int n, input op_t op, input logic w,
                     input logic [8:0] c, input logic [7:0] sc, input shift_t s);
    nx.sh = {s, sc};
    nx.chk[1] = 1'b1;
    ins(b, n, op, w, c, c);
  endtask

  task automatic drain;
    int k;
    k = 0;
    while ((expq.size() != 0 || u_fetch.q.size() != 0) && k < 500) begin
      @(negedge clock);
      k++;
    end
    repeat (3) @(negedge clock);
    if (k >= 500) cmp(29'h2, 29'h0);
  endtask

  task automatic cfg(input logic b8, input logic [7:0] cl, input logic [1:0] gp);
    drain();
    @(posedge clock);
    bus_8bit <= b8;
    count_register_low <= cl;
    gap <= gp;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_group3;
    cfg(1'b0, 8'h00, 2'h1);
    ins(32'hf6e80000, 2, OP_SMUL, 0, 25, 28);
    ins(32'hf7e80000, 2, OP_SMUL, 1, 34, 37);
    ins(32'hf6280000, 2, OP_SMUL, 0, 31, 34);
    ins(32'hf7280000, 2, OP_SMUL, 1, 40, 43);
    ins(32'hf6f00000, 2, OP_UDIV, 0, 29, 29);
    ins(32'hf7f00000, 2, OP_UDIV, 1, 38, 38);
    ins(32'hf6300000, 2, OP_UDIV, 0, 35, 35);
    ins(32'hf7300000, 2, OP_UDIV, 1, 44, 44);
    ins(32'hf6f80000, 2, OP_SDIV, 0, 44, 52);
    ins(32'hf7f80000, 2, OP_SDIV, 1, 53, 61);
    ins(32'hf6380000, 2, OP_SDIV, 0, 50, 58);
    ins(32'hf77f1000, 3, OP_SDIV, 1, 59, 67);
    ins(32'hf7b81234, 4, OP_SDIV, 1, 59, 67);
    ins(32'hf6361234, 4, OP_UDIV, 0, 35, 35);
    imx(16'h0055);
    ins(32'hf6c05500, 3, OP_TEST_IMM, 0, 4, 4);
    imx(16'h1234);
    ins(32'hf7073412, 4, OP_TEST_IMM, 1, 10, 10);
    ins(32'hf6d80000, 2, OP_NONE, 0, 0, 0);
    cfg(1'b1, 8'h00, 2'h0);
    ins(32'hf6280000, 2, OP_SMUL, 0, 32, 34);
    ins(32'hf7280000, 2, OP_SMUL, 1, 44, 47);
    ins(32'hf7e80000, 2, OP_SMUL, 1, 34, 37);
    ins(32'hf7300000, 2, OP_UDIV, 1, 48, 48);
    ins(32'hf7380000, 2, OP_SDIV, 1, 63, 71);
    ins(32'hf7073412, 4, OP_TEST_IMM, 1, 14, 14);
    drain();
  endtask

  task automatic t_misc;
    cfg(1'b0, 8'h00, 2'h0);
    imx(16'h0005);
    ins(32'h6bc10500, 3, OP_SMUL_IMM, 1, 22, 25);
    imx(16'h1234);
    ins(32'h69073412, 4, OP_SMUL_IMM, 1, 29, 32);
    ins(32'h6b471080, 4, OP_SMUL_IMM, 1, 29, 32);
    cfg(1'b1, 8'h00, 2'h0);
    ins(32'hd40a0000, 2, OP_AAM, 0, 19, 19);
    ins(32'hd50a0000, 2, OP_AAD, 1, 15, 15);
    ins(32'hd40b0000, 2, OP_NONE, 0, 0, 0);
    ins(32'h98000000, 1, OP_CBW, 0, 2, 2);
    ins(32'h99000000, 1, OP_CWD, 1, 4, 4);
    ins(32'h90000000, 1, OP_NONE, 0, 0, 0);
    drain();
  endtask

  task automatic t_shift;
    shift_t sl[6];
    logic [7:0] mr;
    logic [7:0] mm;
    sl = '{SH_ROTATE_LEFT, SH_ROTATE_RIGHT, SH_ROTATE_LEFT_CARRY, SH_ROTATE_RIGHT_CARRY, SH_RIGHT_ARITH, SH_LEFT};
    // narrow bus on purpose: shifts carry no word penalty
    cfg(1'b1, 8'h03, 2'h0);
    foreach (sl[i]) begin
      mr = {2'b11, sl[i], 3'h1};
      mm = {2'b00, sl[i], 3'h7};
      shf({8'hd0, mr, 16'h0000}, 2, OP_SHIFT1, 0, 2, 8'h01, sl[i]);
      shf({8'hd1, mm, 16'h0000}, 2, OP_SHIFT1, 1, 15, 8'h01, sl[i]);
      shf({8'hd3, mr, 16'h0000}, 2, OP_SHIFT_CL, 1, 8, 8'h03, sl[i]);
      shf({8'hd2, mm, 16'h0000}, 2, OP_SHIFT_CL, 0, 20, 8'h03, sl[i]);
      shf({8'hc1, mr, 8'h07, 8'h00}, 3, OP_SHIFT_IMM, 1, 12, 8'h07, sl[i]);
      shf({8'hc0, mm, 8'h00, 8'h00}, 3, OP_SHIFT_IMM, 0, 17, 8'h00, sl[i]);
    end
    ins(32'hd0e00000, 2, OP_NONE, 0, 0, 0);
    ins(32'hd0f80000, 2, OP_NONE, 0, 0, 0);
    cfg(1'b0, 8'hff, 2'h1);
    shf(32'hd3c00000, 2, OP_SHIFT_CL, 1, 260, 8'hff, SH_ROTATE_LEFT);
    shf(32'hd2070000, 2, OP_SHIFT_CL, 0, 272, 8'hff, SH_ROTATE_LEFT);
    drain();
  endtask

  task automatic t_logic;
    cfg(1'b0, 8'h00, 2'h0);
    dirx(1'b0);
    ins(32'h20c10000, 2, OP_AND_RM, 0, 3, 3);
    dirx(1'b1);
    ins(32'h23070000, 2, OP_AND_RM, 1, 10, 10);
    dirx(1'b1);
    ins(32'h0ac80000, 2, OP_OR_RM, 0, 3, 3);
    dirx(1'b0);
    ins(32'h093f0000, 2, OP_OR_RM, 1, 10, 10);
    imx(16'h0012);
    ins(32'h80e01200, 3, OP_AND_IMM, 0, 4, 4);
    imx(16'h1234);
    ins(32'h81cf3412, 4, OP_OR_IMM, 1, 4, 4);
    ins(32'h800f5500, 3, OP_OR_IMM, 0, 16, 16);
    imx(16'h005a);
    ins(32'h245a0000, 2, OP_AND_ACC, 0, 3, 3);
    imx(16'habcd);
    ins(32'h25cdab00, 3, OP_AND_ACC, 1, 4, 4);
    ins(32'h0c110000, 2, OP_OR_ACC, 0, 3, 3);
    ins(32'h0d221100, 3, OP_OR_ACC, 1, 4, 4);
    ins(32'h84c00000, 2, OP_TEST_RM, 0, 3, 3);
    ins(32'ha8120000, 2, OP_TEST_ACC, 0, 3, 3);
    imx(16'h1234);
    ins(32'ha9341200, 3, OP_TEST_ACC, 1, 4, 4);
    cfg(1'b1, 8'h00, 2'h0);
    ins(32'h23070000, 2, OP_AND_RM, 1, 14, 14);
    ins(32'h093f0000, 2, OP_OR_RM, 1, 18, 18);
    ins(32'h810f3412, 4, OP_OR_IMM, 1, 24, 24);
    ins(32'h85070000, 2, OP_TEST_RM, 1, 10, 10);
    ins(32'h25cdab00, 3, OP_AND_ACC, 1, 4, 4);
    drain();
  endtask

  // reset lands in mid-instruction and must leave nothing behind
  task automatic t_reset;
    cfg(1'b0, 8'h00, 2'h0);
    @(negedge clock);
    u_fetch.push(8'hf7);
    repeat (3) @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    @(negedge clock);
    cmp({|out_decode, |out_timing, out_valid}, 29'h0);
    @(posedge clock);
    rst <= 1'b0;
    ins(32'h98000000, 1, OP_CBW, 0, 2, 2);
    drain();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    bus_8bit = 1'b0;
    count_register_low = 8'h00;
    gap = 2'h0;
    n_mismatch = 0;
    n_checks = 0;
    nx = '0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_group3();
    t_misc();
    t_shift();
    t_logic();
    t_reset();
    report_and_stop();
  end

  // the whole run needs well under a few thousand cycles
  initial begin
    #500000;
    n_mismatch++;
    report_and_stop();
  end
endmodule

// File: verilog/muldiv_defs.svh
`ifndef MULDIV_DEFS_SVH
`define MULDIV_DEFS_SVH
// opcode patterns, compared against the upper opcode bits or against the whole byte
`define OPC7_GROUP3 7'h7b
`define OPC6_SMUL_IMM 6'h1a
`define OPC7_SHIFT_ONE 7'h68
`define OPC7_SHIFT_CNT 7'h69
`define OPC7_SHIFT_IMM 7'h60
`define OPC6_AND_RM 6'h08
`define OPC6_OR_RM 6'h02
`define OPC7_LOGIC_IMM 7'h40
`define OPC7_AND_ACC 7'h12
`define OPC7_OR_ACC 7'h06
`define OPC7_TEST_RM 7'h42
`define OPC7_TEST_ACC 7'h54
`define OPC_AAM 8'hd4
`define OPC_AAD 8'hd5
`define OPC_CBW 8'h98
`define OPC_CWD 8'h99
`define AAX_BASE 8'h0a
// modrm field positions and reg-field codes
`define MRM_MOD_HI 7
`define MRM_MOD_LO 6
`define MRM_REG_HI 5
`define MRM_REG_LO 3
`define REG_TEST_IMM 3'h0
`define REG_OR_IMM 3'h1
`define REG_AND_IMM 3'h4
`define REG_SMUL 3'h5
`define REG_UDIV 3'h6
`define REG_SDIV 3'h7
// clock counts
`define CYC_SMUL_RB 18'h0321c
`define CYC_SMUL_RW 18'h04425
`define CYC_SMUL_MB 18'h03e22
`define CYC_SMUL_MB8_MIN 9'h020
`define CYC_SMUL_MW 18'h0502b
`define CYC_SMULI_R 18'h02c19
`define CYC_SMULI_M 18'h03a20
`define CYC_UDIV_RB 9'h01d
`define CYC_UDIV_RW 9'h026
`define CYC_UDIV_MB 9'h023
`define CYC_UDIV_MW 9'h02c
`define CYC_SDIV_RB 18'h05834
`define CYC_SDIV_RW 18'h06a3d
`define CYC_SDIV_MB 18'h0643a
`define CYC_SDIV_MW 18'h07643
`define CYC_AAM 9'h013
`define CYC_AAD 9'h00f
`define CYC_CBW 9'h002
`define CYC_CWD 9'h004
`define CYC_SHIFT1_R 9'h002
`define CYC_SHIFT1_M 9'h00f
`define CYC_SHIFTN_R 9'h005
`define CYC_SHIFTN_M 9'h011
`define CYC_LOGIC_R 9'h003
`define CYC_LOGIC_M 9'h00a
`define CYC_LOGIC_IMM_R 9'h004
`define CYC_LOGIC_IMM_M 9'h010
`define CYC_ACC_B 9'h003
`define CYC_ACC_W 9'h004
`define CYC_TEST_IMM_R 9'h004
`define CYC_TEST_IMM_M 9'h00a
`define CYC_WORD_XFER 9'h004
`endif

// File: verilog/muldiv_pkg.sv
package muldiv_pkg;
  typedef enum logic [4:0] {
    OP_NONE, OP_SMUL, OP_SMUL_IMM, OP_UDIV, OP_SDIV, OP_AAM, OP_AAD, OP_CBW, OP_CWD,
    OP_SHIFT1, OP_SHIFT_CL, OP_SHIFT_IMM, OP_AND_RM, OP_OR_RM, OP_AND_IMM, OP_OR_IMM,
    OP_AND_ACC, OP_OR_ACC, OP_TEST_RM, OP_TEST_IMM, OP_TEST_ACC
  } op_t;
  // values equal the selector field code
  typedef enum logic [2:0] {
    SH_ROTATE_LEFT = 3'h0, SH_ROTATE_RIGHT = 3'h1, SH_ROTATE_LEFT_CARRY = 3'h2,
    SH_ROTATE_RIGHT_CARRY = 3'h3, SH_RIGHT_ARITH = 3'h5, SH_LEFT = 3'h6
  } shift_t;
  typedef enum logic [1:0] {
    ST_OPCODE = 2'b00, ST_MODRM = 2'b01, ST_DISP = 2'b11, ST_IMM = 2'b10
  } state_t;
  typedef struct packed {
    logic recognised;
    op_t op;
    shift_t shift_op;
    logic width_word;
    logic dir_to_reg;
    logic mem_operand;
    logic writes_mem;
    logic [2:0] reg_sel;
    logic [2:0] rm_sel;
    logic [15:0] imm;
    logic [7:0] shift_count;
    logic [3:0] length;
  } decode_t;
  typedef struct packed {
    logic [8:0] cyc_min;
    logic [8:0] cyc_max;
  } timing_t;
endpackage

// File: verilog/muldiv_shift_logic_decode.sv
`timescale 1ns/1ps
`include "muldiv_defs.svh"
module muldiv_shift_logic_decode (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // instruction byte stream from fetch
  input wire logic in_valid,
  input wire logic [7:0] in_byte,
  // core context
  input wire logic bus_8bit,
  input wire logic [7:0] count_register_low,
  // decode result, one-cycle pulse
  output logic out_valid,
  output muldiv_pkg::decode_t out_decode,
  output muldiv_pkg::timing_t out_timing
);
  import muldiv_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic op_t classify(input logic [7:0] opc, input logic [7:0] mrm);
    op_t op;
    logic [2:0] rf;
    logic sel_ok;
    rf = mrm[`MRM_REG_HI:`MRM_REG_LO];
    // selector codes 100 and 111 are not part of this group
    sel_ok = rf != 3'h4 && rf != 3'h7;
    op = OP_NONE;
    case (opc[7:1])
      `OPC7_GROUP3: begin
        case (rf)
          `REG_SMUL: op = OP_SMUL;
          `REG_UDIV: op = OP_UDIV;
          `REG_SDIV: op = OP_SDIV;
          `REG_TEST_IMM: op = OP_TEST_IMM;
          default: op = OP_NONE;
        endcase
      end
      {`OPC6_SMUL_IMM, 1'b0}, {`OPC6_SMUL_IMM, 1'b1}: op = opc[0] ? OP_SMUL_IMM : OP_NONE;
      `OPC7_SHIFT_ONE: op = sel_ok ? OP_SHIFT1 : OP_NONE;
      `OPC7_SHIFT_CNT: op = sel_ok ? OP_SHIFT_CL : OP_NONE;
      `OPC7_SHIFT_IMM: op = sel_ok ? OP_SHIFT_IMM : OP_NONE;
      {`OPC6_AND_RM, 1'b0}, {`OPC6_AND_RM, 1'b1}: op = OP_AND_RM;
      {`OPC6_OR_RM, 1'b0}, {`OPC6_OR_RM, 1'b1}: op = OP_OR_RM;
      `OPC7_LOGIC_IMM: op = (rf == `REG_AND_IMM) ? OP_AND_IMM : (rf == `REG_OR_IMM) ? OP_OR_IMM : OP_NONE;
      `OPC7_AND_ACC: op = OP_AND_ACC;
      `OPC7_OR_ACC: op = OP_OR_ACC;
      `OPC7_TEST_RM: op = OP_TEST_RM;
      `OPC7_TEST_ACC: op = OP_TEST_ACC;
      default: begin
        case (opc)
          `OPC_AAM: op = OP_AAM;
          `OPC_AAD: op = OP_AAD;
          `OPC_CBW: op = OP_CBW;
          `OPC_CWD: op = OP_CWD;
          default: op = OP_NONE;
        endcase
      end
    endcase
    return op;
  endfunction

  // opcode alone tells whether a modrm byte follows
  function automatic logic has_modrm(input logic [7:0] opc);
    return opc[7:1] == `OPC7_GROUP3 || (opc[7:2] == `OPC6_SMUL_IMM && opc[0]) ||
      opc[7:1] == `OPC7_SHIFT_ONE || opc[7:1] == `OPC7_SHIFT_CNT || opc[7:1] == `OPC7_SHIFT_IMM ||
      opc[7:2] == `OPC6_AND_RM || opc[7:2] == `OPC6_OR_RM || opc[7:1] == `OPC7_LOGIC_IMM ||
      opc[7:1] == `OPC7_TEST_RM;
  endfunction

  function automatic logic [1:0] imm_bytes(input op_t op, input logic [7:0] opc);
    case (op)
      OP_SMUL_IMM: return opc[1] ? 2'd1 : 2'd2;
      OP_SHIFT_IMM: return 2'd1;
      OP_AND_IMM, OP_OR_IMM, OP_AND_ACC, OP_OR_ACC, OP_TEST_IMM, OP_TEST_ACC:
        return opc[0] ? 2'd2 : 2'd1;
      default: return 2'd0;
    endcase
  endfunction

  function automatic logic [1:0] disp_bytes(input logic [7:0] mrm);
    case (mrm[`MRM_MOD_HI:`MRM_MOD_LO])
      2'b00: return (mrm[2:0] == 3'h6) ? 2'd2 : 2'd0;
      2'b01: return 2'd1;
      2'b10: return 2'd2;
      default: return 2'd0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  state_t state_q, state_d;
  logic [7:0] opc_q, opc_d, mrm_q, mrm_d;
  logic [1:0] disp_q, disp_d, imm_left_q, imm_left_d;
  logic [15:0] imm_q, imm_d;
  logic [3:0] len_q, len_d;
  logic hit_q, hit_d, emit_d, emit_q;
  logic [7:0] cl_q, cl_d;

  always_comb begin
    op_t op;
    logic [1:0] nd, ni;
    op = OP_NONE;
    nd = 2'd0;
    ni = 2'd0;
    state_d = state_q;
    opc_d = opc_q;
    mrm_d = mrm_q;
    disp_d = disp_q;
    imm_left_d = imm_left_q;
    imm_d = imm_q;
    len_d = len_q;
    hit_d = hit_q;
    cl_d = cl_q;
    emit_d = 1'b0;
    if (in_valid) begin
      len_d = len_q + 4'd1;
      case (state_q)
        ST_OPCODE: begin
          opc_d = in_byte;
          mrm_d = 8'h00;
          imm_d = 16'h0000;
          len_d = 4'd1;
          cl_d = count_register_low;
          op = classify(in_byte, 8'h00);
          ni = imm_bytes(op, in_byte);
          if (has_modrm(in_byte) || op == OP_AAM || op == OP_AAD) begin
            state_d = ST_MODRM;
          end else if (ni != 2'd0) begin
            imm_left_d = ni;
            state_d = ST_IMM;
          end else begin
            hit_d = (op == OP_CBW || op == OP_CWD);
            emit_d = 1'b1;
          end
        end
        ST_MODRM: begin
          mrm_d = in_byte;
          op = classify(opc_q, in_byte);
          if (op == OP_AAM || op == OP_AAD) begin
            hit_d = (in_byte == `AAX_BASE);
            emit_d = 1'b1;
            state_d = ST_OPCODE;
          end else if (op == OP_NONE) begin
            hit_d = 1'b0;
            emit_d = 1'b1;
            state_d = ST_OPCODE;
          end else begin
            hit_d = 1'b1;
            nd = disp_bytes(in_byte);
            ni = imm_bytes(op, opc_q);
            disp_d = nd;
            imm_left_d = ni;
            if (nd != 2'd0) begin
              state_d = ST_DISP;
            end else if (ni != 2'd0) begin
              state_d = ST_IMM;
            end else begin
              emit_d = 1'b1;
              state_d = ST_OPCODE;
            end
          end
        end
        ST_DISP: begin
          disp_d = disp_q - 2'd1;
          if (disp_q == 2'd1) begin
            state_d = (imm_left_q != 2'd0) ? ST_IMM : ST_OPCODE;
            emit_d = (imm_left_q == 2'd0);
          end
        end
        ST_IMM: begin
          imm_left_d = imm_left_q - 2'd1;
          // low byte arrives first; a single byte lands low
          if (imm_left_q == imm_bytes(classify(opc_q, mrm_q), opc_q)) begin
            imm_d = {imm_q[15:8], in_byte};
          end else begin
            imm_d = {in_byte, imm_q[7:0]};
          end
          if (imm_left_q == 2'd1) begin
            hit_d = (state_q == ST_IMM) ? (hit_q | (classify(opc_q, mrm_q) != OP_NONE)) : hit_q;
            emit_d = 1'b1;
            state_d = ST_OPCODE;
          end
        end
        default: state_d = ST_OPCODE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= ST_OPCODE;
      opc_q <= 8'h00;
      mrm_q <= 8'h00;
      disp_q <= 2'd0;
      imm_left_q <= 2'd0;
      imm_q <= 16'h0000;
      len_q <= 4'h0;
      hit_q <= 1'b0;
      emit_q <= 1'b0;
      cl_q <= 8'h00;
    end else begin
      state_q <= state_d;
      opc_q <= opc_d;
      mrm_q <= mrm_d;
      disp_q <= disp_d;
      imm_left_q <= imm_left_d;
      imm_q <= imm_d;
      len_q <= len_d;
      hit_q <= hit_d;
      emit_q <= emit_d;
      cl_q <= cl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  decode_t dec_d, dec_q;
  timing_t tim_d, tim_q;

  always_comb begin
    logic word, mem;
    logic [8:0] n, pen;
    dec_d = dec_q;
    tim_d = tim_q;
    word = opc_d[0];
    mem = (mrm_d[`MRM_MOD_HI:`MRM_MOD_LO] != 2'b11) && has_modrm(opc_d);
    n = 9'h000;
    pen = 9'h000;
    if (emit_d) begin
      dec_d.recognised = hit_d;
      dec_d.op = hit_d ? classify(opc_d, mrm_d) : OP_NONE;
      dec_d.shift_op = shift_t'(mrm_d[`MRM_REG_HI:`MRM_REG_LO]);
      dec_d.width_word = word;
      dec_d.dir_to_reg = opc_d[1] && (dec_d.op == OP_AND_RM || dec_d.op == OP_OR_RM);
      dec_d.mem_operand = mem;
      dec_d.writes_mem = mem && (dec_d.op inside {OP_SHIFT1, OP_SHIFT_CL, OP_SHIFT_IMM, OP_AND_IMM, OP_OR_IMM} ||
        (dec_d.op inside {OP_AND_RM, OP_OR_RM} && !opc_d[1]));
      dec_d.reg_sel = mrm_d[`MRM_REG_HI:`MRM_REG_LO];
      dec_d.rm_sel = mrm_d[2:0];
      dec_d.imm = imm_d;
      dec_d.shift_count = (dec_d.op == OP_SHIFT_CL) ? cl_d : (dec_d.op == OP_SHIFT_IMM) ? imm_d[7:0] : 8'h01;
      dec_d.length = len_d;
      n = {1'b0, dec_d.shift_count};
      // narrow bus: word memory multiply (not the immediate form), divide, AND, OR and TEST-immediate pay one transfer, read-modify-write pays twice
      if (bus_8bit && word && mem &&
          dec_d.op inside {OP_SMUL, OP_UDIV, OP_SDIV, OP_AND_RM, OP_OR_RM, OP_AND_IMM, OP_OR_IMM, OP_TEST_IMM}) begin
        pen = dec_d.writes_mem ? (`CYC_WORD_XFER << 1) : `CYC_WORD_XFER;
      end
      case (dec_d.op)
        OP_SMUL: begin
          tim_d = mem ? (word ? `CYC_SMUL_MW : `CYC_SMUL_MB) : (word ? `CYC_SMUL_RW : `CYC_SMUL_RB);
          if (mem && !word && bus_8bit) begin
            tim_d.cyc_min = `CYC_SMUL_MB8_MIN;
          end
        end
        OP_SMUL_IMM: tim_d = mem ? `CYC_SMULI_M : `CYC_SMULI_R;
        OP_UDIV:
          tim_d = {2{mem ? (word ? `CYC_UDIV_MW : `CYC_UDIV_MB) : (word ? `CYC_UDIV_RW : `CYC_UDIV_RB)}};
        OP_SDIV: tim_d = mem ? (word ? `CYC_SDIV_MW : `CYC_SDIV_MB) : (word ? `CYC_SDIV_RW : `CYC_SDIV_RB);
        OP_AAM: tim_d = {`CYC_AAM, `CYC_AAM};
        OP_AAD: tim_d = {`CYC_AAD, `CYC_AAD};
        OP_CBW: tim_d = {`CYC_CBW, `CYC_CBW};
        OP_CWD: tim_d = {`CYC_CWD, `CYC_CWD};
        OP_SHIFT1: tim_d = mem ? {`CYC_SHIFT1_M, `CYC_SHIFT1_M} : {`CYC_SHIFT1_R, `CYC_SHIFT1_R};
        OP_SHIFT_CL, OP_SHIFT_IMM: tim_d = {2{(mem ? `CYC_SHIFTN_M : `CYC_SHIFTN_R) + n}};
        OP_AND_RM, OP_OR_RM, OP_TEST_RM:
          tim_d = mem ? {`CYC_LOGIC_M, `CYC_LOGIC_M} : {`CYC_LOGIC_R, `CYC_LOGIC_R};
        OP_AND_IMM, OP_OR_IMM:
          tim_d = mem ? {`CYC_LOGIC_IMM_M, `CYC_LOGIC_IMM_M} : {`CYC_LOGIC_IMM_R, `CYC_LOGIC_IMM_R};
        OP_AND_ACC, OP_OR_ACC, OP_TEST_ACC:
          tim_d = word ? {`CYC_ACC_W, `CYC_ACC_W} : {`CYC_ACC_B, `CYC_ACC_B};
        OP_TEST_IMM: tim_d = mem ? {`CYC_TEST_IMM_M, `CYC_TEST_IMM_M} : {`CYC_TEST_IMM_R, `CYC_TEST_IMM_R};
        default: tim_d = 18'h00000;
      endcase
      tim_d.cyc_min = tim_d.cyc_min + pen;
      tim_d.cyc_max = tim_d.cyc_max + pen;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      dec_q <= '0;
      tim_q <= '0;
    end else begin
      dec_q <= dec_d;
      tim_q <= tim_d;
    end
  end

  assign out_valid = emit_q;
  assign out_decode = dec_q;
  assign out_timing = tim_q;

  ////////////////////////////////////////////////////////////////////////////////
  a_smul_spread: assert property (@(posedge clock) disable iff (rst)
    out_valid && out_decode.op == OP_SMUL && !out_decode.mem_operand |->
    out_timing.cyc_max - out_timing.cyc_min == 9'h003) else $error("signed multiply range wrong");
  a_udiv_fixed: assert property (@(posedge clock) disable iff (rst)
    out_valid && out_decode.op == OP_UDIV && !out_decode.mem_operand |->
    out_timing.cyc_min == (out_decode.width_word ? 9'h026 : 9'h01d)) else $error("divide count wrong");
  a_sdiv_spread: assert property (@(posedge clock) disable iff (rst)
    out_valid && out_decode.op == OP_SDIV && !out_decode.mem_operand |->
    out_timing.cyc_max - out_timing.cyc_min == 9'h008) else $error("signed divide range wrong");
  a_adjust_cycles: assert property (@(posedge clock) disable iff (rst)
    state_q == ST_OPCODE && in_valid && in_byte == 8'hd4 ##1 in_valid && in_byte == 8'h0a |=>
    out_valid && out_decode.recognised && out_timing.cyc_min == 9'h013) else $error("product adjust wrong");
  a_extend_byte: assert property (@(posedge clock) disable iff (rst)
    state_q == ST_OPCODE && in_valid && in_byte == 8'h98 |=>
    out_valid && out_decode.op == OP_CBW && out_timing.cyc_max == 9'h002) else $error("byte extend wrong");
  a_extend_word: assert property (@(posedge clock) disable iff (rst)
    state_q == ST_OPCODE && in_valid && in_byte == 8'h99 |=>
    out_valid && out_timing.cyc_min == 9'h004 && out_decode.length == 4'd1) else $error("word extend wrong");
  a_shift_count: assert property (@(posedge clock) disable iff (rst)
    out_valid && out_decode.op == OP_SHIFT_CL && !out_decode.mem_operand |->
    out_timing.cyc_min == 9'h005 + {1'b0, out_decode.shift_count}) else $error("shift count timing wrong");
  a_logic_reg: assert property (@(posedge clock) disable iff (rst)
    out_valid && out_decode.op inside {OP_AND_RM, OP_OR_RM, OP_TEST_RM} && !out_decode.mem_operand |->
    out_timing.cyc_min == 9'h003) else $error("logic register timing wrong");
  a_acc_length: assert property (@(posedge clock) disable iff (rst)
    out_valid && out_decode.op == OP_TEST_ACC |->
    out_decode.length == (out_decode.width_word ? 4'd3 : 4'd2)) else $error("accumulator test length wrong");
endmodule
